// File: shared/mbs_defines.svh
// Purpose: constants of the serial register-access slave
// Assumes: 250 MHz ref_clk
// Notes: offsets are register numbers on the serial protocol
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH
`define MB_FC_RD_HOLD 8'h03
`define MB_FC_RD_IN 8'h04
`define MB_FC_WR_ONE 8'h06
`define MB_FC_WR_MULTI 8'h10
`define MB_FC_IDENT 8'h11
`define MB_EXC_FLAG 8'h80
`define MB_EXC_FUNC 8'h01
`define MB_EXC_ADDR 8'h02
`define MB_EXC_VALUE 8'h03
`define MB_BASE_FLT 16'h1d4c
`define MB_BASE_M7 16'h1b58
`define MB_BASE_M6 16'h1770
`define MB_BASE_INT 16'h0fa0
`define MB_MAX_REGS 16'h0010
`define MB_CRC_INIT 16'hffff
`define MB_CRC_POLY 16'ha001
`define MB_IDENT_BYTES 8'h02
`define MB_RUN_STATUS 8'hff
`define MB_RESP_MAX_MS 200
`define MB_CLK_MHZ 250
`define MB_RESP_CYC (`MB_RESP_MAX_MS * 1000 * `MB_CLK_MHZ)
`endif

// File: shared/mbs_pkg.sv
// Purpose: types of the serial register-access slave
// Assumes: nothing
// Notes: none
package mbs_pkg;
  typedef enum logic [1:0] {ST_RECV, ST_CHECK, ST_WRITE, ST_RESP} state_t;
  typedef enum logic [2:0] {AR_NONE, AR_FLT, AR_M7, AR_M6, AR_INT} area_t;
  typedef enum logic [1:0] {RS_READ, RS_ECHO, RS_EXC, RS_IDENT} rsp_t;
endpackage : mbs_pkg

// File: logic/mbs_slave.sv
// Purpose: frame decode, register access and answer build for a serial slave
// Assumes: a uart layer on ref_clk delivers bytes and an end-of-frame pulse
// Notes: answers leave through a registered fifo
`timescale 1ns/1ps
`include "mbs_defines.svh"

// ----------------------------------------
// answer fifo
// ----------------------------------------
module mbs_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 32) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr, rd, next_wr, next_rd;
  logic [WIDTH-1:0] next_out_data;
  logic next_out_valid, next_in_ready, load;
  // pointer and output stage update
  always_comb begin
    load = (wr != rd) && (!out_valid || out_ready);
    next_rd = load ? rd + 1'b1 : rd;
    next_wr = (in_valid && in_ready) ? wr + 1'b1 : wr;
    next_out_data = load ? mem[rd[AW-1:0]] : out_data;
    next_out_valid = load || (out_valid && !out_ready);
    next_in_ready = (next_wr - next_rd) < (AW+1)'(DEPTH); // honest full
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr <= '0;
      rd <= '0;
      out_data <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
      out_data <= next_out_data;
      out_valid <= next_out_valid;
      in_ready <= next_in_ready;
    end
  end
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wr[AW-1:0]] <= in_data;
  end
  a_out_hold: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
endmodule : mbs_fifo

// ----------------------------------------
// slave core
// ----------------------------------------
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int NFLT = 8,
  parameter int NINT = 16,
  parameter int RXN = 32,
  parameter int FIFO_DEPTH = 32,
  parameter int RESP_CYC = `MB_RESP_CYC,
  parameter logic [7:0] IDENT_CODE = 8'h5a // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] slave_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_char_err,
  input wire logic rx_frame_end,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic frame_drop,
  input wire logic meas_we,
  input wire logic [$clog2(NFLT)-1:0] meas_idx,
  input wire logic [31:0] meas_val
);
  localparam int RW = $clog2(RXN);
  localparam int FW = $clog2(NFLT);
  localparam int IW = $clog2(NINT);

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_upd

  function automatic area_t area_of(input logic [15:0] s, input logic [15:0] n);
    logic [16:0] e;
    e = {1'b0, s} + {1'b0, n};
    if (s >= `MB_BASE_FLT && e <= 17'(`MB_BASE_FLT) + 17'(NFLT)) return AR_FLT;
    if (s >= `MB_BASE_M7 && e <= 17'(`MB_BASE_M7) + 17'(2*NFLT)) return AR_M7;
    if (s >= `MB_BASE_M6 && e <= 17'(`MB_BASE_M6) + 17'(2*NFLT)) return AR_M6;
    if (s >= `MB_BASE_INT && e <= 17'(`MB_BASE_INT) + 17'(NINT)) return AR_INT;
    return AR_NONE;
  endfunction : area_of

  state_t state, next_state;
  area_t area, next_area;
  rsp_t kind, next_kind;
  logic [7:0] buf_q [RXN];
  logic [7:0] next_buf [RXN];
  logic [31:0] flt [NFLT];
  logic [31:0] next_flt [NFLT];
  logic [15:0] ints [NINT];
  logic [15:0] next_ints [NINT];
  logic [RW:0] rx_cnt, next_rx_cnt;
  logic [15:0] crc, next_crc;
  logic rx_bad, next_rx_bad, next_drop, push, push_ready;
  logic [7:0] tidx, next_tidx, rlen, next_rlen, exc, next_exc, tbyte, push_data, i8;
  logic [31:0] wdog, next_wdog;
  logic [15:0] start, cnt, ofs, w16;
  logic [7:0] fc, nbytes;
  logic [31:0] fv;

  assign fc = buf_q[1];
  assign start = {buf_q[2], buf_q[3]};
  assign cnt = {buf_q[4], buf_q[5]};

  // answer byte at position tidx
  always_comb begin
    i8 = tidx - 8'h03;
    ofs = '0;
    w16 = '0;
    fv = '0;
    tbyte = '0;
    case (area)
      AR_FLT: ofs = start - `MB_BASE_FLT + 16'(i8[7:2]);
      AR_M7: ofs = start - `MB_BASE_M7 + 16'(i8[7:1]);
      AR_M6: ofs = start - `MB_BASE_M6 + 16'(i8[7:1]);
      default: ofs = start - `MB_BASE_INT + 16'(i8[7:1]);
    endcase
    fv = flt[area == AR_FLT ? ofs[FW-1:0] : ofs[FW:1]];
    w16 = ints[ofs[IW-1:0]];
    if (tidx == 8'h00) begin
      tbyte = buf_q[0];
    end else if (tidx == 8'h01) begin
      tbyte = (kind == RS_EXC) ? (fc | `MB_EXC_FLAG) : fc;
    end else if (kind == RS_EXC) begin
      tbyte = exc;
    end else if (kind == RS_ECHO) begin
      tbyte = buf_q[tidx[RW-1:0]];
    end else if (kind == RS_IDENT) begin
      tbyte = (tidx == 8'h02) ? `MB_IDENT_BYTES : (tidx == 8'h03) ? IDENT_CODE : `MB_RUN_STATUS;
    end else if (tidx == 8'h02) begin
      tbyte = rlen - 8'h05;
    end else begin
      case (area)
        // concatenation keeps the inverted byte index at two bits
        AR_FLT: tbyte = fv[{~i8[1:0], 3'b000} +: 8];
        AR_M7: tbyte = fv[8*{~ofs[0], ~i8[0]} +: 8];
        AR_M6: tbyte = fv[8*{ofs[0], ~i8[0]} +: 8];
        default: tbyte = i8[0] ? w16[7:0] : w16[15:8];
      endcase
    end
    push_data = (tidx == rlen - 8'h02) ? crc[7:0] : (tidx == rlen - 8'h01) ? crc[15:8] : tbyte;
  end

  // ----------------------------------------
  // frame receive, decode, write and answer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_area = area;
    next_kind = kind;
    next_buf = buf_q;
    next_flt = flt;
    next_ints = ints;
    next_rx_cnt = rx_cnt;
    next_crc = crc;
    next_rx_bad = rx_bad;
    next_drop = 1'b0;
    next_tidx = tidx;
    next_rlen = rlen;
    next_exc = exc;
    next_wdog = wdog;
    push = 1'b0;
    nbytes = '0;
    if (meas_we) next_flt[meas_idx] = meas_val;
    case (state)
      ST_RECV: begin
        if (rx_valid) begin
          if (rx_cnt < (RW+1)'(RXN)) next_buf[rx_cnt[RW-1:0]] = rx_data;
          else next_rx_bad = 1'b1;
          if (rx_cnt < (RW+1)'(RXN)) next_rx_cnt = rx_cnt + 1'b1;
          next_crc = crc_upd(crc, rx_data);
          if (rx_char_err) next_rx_bad = 1'b1;
        end
        // gap at the chosen baud rate closes the frame
        if (rx_frame_end) begin
          if (rx_cnt >= (RW+1)'(4) && crc == 16'h0000 && !rx_bad && buf_q[0] == slave_addr)
            next_state = ST_CHECK;
          else next_drop = 1'b1;
          // an accepted frame keeps its length for the write check
          if (next_drop) next_rx_cnt = '0;
          next_crc = `MB_CRC_INIT;
          next_rx_bad = 1'b0;
        end
      end
      ST_CHECK: begin
        next_rx_cnt = '0;
        next_tidx = '0;
        next_wdog = '0;
        next_state = ST_RESP;
        next_kind = RS_EXC;
        next_rlen = 8'h05;
        next_exc = `MB_EXC_FUNC;
        case (fc)
          `MB_FC_RD_HOLD, `MB_FC_RD_IN: begin
            next_area = area_of(start, cnt);
            nbytes = (next_area == AR_FLT) ? {cnt[5:0], 2'b00} : {1'b0, cnt[5:0], 1'b0};
            if (cnt == '0 || cnt > `MB_MAX_REGS) next_exc = `MB_EXC_VALUE;
            else if (next_area == AR_NONE) next_exc = `MB_EXC_ADDR;
            else begin
              next_kind = RS_READ;
              next_rlen = 8'h05 + nbytes;
            end
          end
          `MB_FC_WR_ONE: begin
            next_area = area_of(start, 16'h0001);
            if (next_area != AR_INT) next_exc = `MB_EXC_ADDR;
            else begin
              next_kind = RS_ECHO;
              next_rlen = 8'h08;
              next_state = ST_WRITE;
            end
          end
          `MB_FC_WR_MULTI: begin
            next_area = area_of(start, cnt);
            nbytes = (next_area == AR_FLT) ? {cnt[5:0], 2'b00} : {1'b0, cnt[5:0], 1'b0};
            if (cnt == '0 || cnt > `MB_MAX_REGS || buf_q[6] != nbytes
                || 8'(rx_cnt) != nbytes + 8'h09) next_exc = `MB_EXC_VALUE;
            else if (next_area != AR_FLT && next_area != AR_INT) next_exc = `MB_EXC_ADDR;
            else begin
              next_kind = RS_ECHO;
              next_rlen = 8'h08;
              next_state = ST_WRITE;
            end
          end
          `MB_FC_IDENT: begin
            next_kind = RS_IDENT;
            next_rlen = 8'h07;
          end
          default: next_exc = `MB_EXC_FUNC;
        endcase
      end
      ST_WRITE: begin
        // one register per cycle, tidx counts registers
        if (fc == `MB_FC_WR_ONE) begin
          next_ints[IW'(start - `MB_BASE_INT)] = cnt;
          next_tidx = '0;
          next_state = ST_RESP;
        end else begin
          if (area == AR_FLT)
            next_flt[FW'(start - `MB_BASE_FLT + 16'(tidx))] = {buf_q[RW'(7 + 4*tidx)],
              buf_q[RW'(8 + 4*tidx)], buf_q[RW'(9 + 4*tidx)], buf_q[RW'(10 + 4*tidx)]};
          else
            next_ints[IW'(start - `MB_BASE_INT + 16'(tidx))] =
              {buf_q[RW'(7 + 2*tidx)], buf_q[RW'(8 + 2*tidx)]};
          next_tidx = tidx + 1'b1;
          if (16'(tidx) + 16'h0001 == cnt) begin
            next_tidx = '0;
            next_state = ST_RESP;
          end
        end
      end
      default: begin
        push = push_ready;
        if (tidx == 8'h00 && !push_ready) next_wdog = wdog + 1;
        if (push_ready) begin
          if (tidx < rlen - 8'h02) next_crc = crc_upd(crc, tbyte);
          next_tidx = tidx + 1'b1;
          if (tidx == rlen - 8'h01) begin
            next_state = ST_RECV;
            next_crc = `MB_CRC_INIT;
          end
        end else if (tidx == 8'h00 && wdog == 32'(RESP_CYC - 1)) begin
          next_state = ST_RECV;
          next_drop = 1'b1;
        end
      end
    endcase
    if (state == ST_CHECK) next_crc = `MB_CRC_INIT;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RECV;
      area <= AR_NONE;
      kind <= RS_EXC;
      rx_cnt <= '0;
      crc <= `MB_CRC_INIT;
      rx_bad <= 1'b0;
      frame_drop <= 1'b0;
      tidx <= '0;
      rlen <= '0;
      exc <= '0;
      wdog <= '0;
      for (int k = 0; k < NFLT; k++) flt[k] <= '0;
      for (int k = 0; k < NINT; k++) ints[k] <= '0;
      for (int k = 0; k < RXN; k++) buf_q[k] <= '0;
    end else begin
      state <= next_state;
      area <= next_area;
      kind <= next_kind;
      rx_cnt <= next_rx_cnt;
      crc <= next_crc;
      rx_bad <= next_rx_bad;
      frame_drop <= next_drop;
      tidx <= next_tidx;
      rlen <= next_rlen;
      exc <= next_exc;
      wdog <= next_wdog;
      flt <= next_flt;
      ints <= next_ints;
      buf_q <= next_buf;
    end
  end

  mbs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk), .rst_n(rst_n), .in_data(push_data), .in_valid(push),
    .in_ready(push_ready), .out_data(tx_data), .out_valid(tx_valid), .out_ready(tx_ready)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_then_resp;
    state == ST_WRITE ##1 state == ST_RESP;
  endsequence
  a_bad_frame_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RECV && rx_frame_end && (crc != 16'h0000 || buf_q[0] != slave_addr)
    |=> state == ST_RECV && frame_drop) else $error("bad frame not dropped");
  a_char_err_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RECV && rx_valid && rx_char_err && !rx_frame_end
    |=> rx_bad until_with rx_frame_end) else $error("char error forgotten");
  a_good_frame_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RECV && rx_frame_end && crc == 16'h0000 && !rx_bad
    && rx_cnt >= (RW+1)'(4) && buf_q[0] == slave_addr |=> state == ST_CHECK)
    else $error("good frame lost");
  a_unknown_func: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_CHECK && !(fc inside {`MB_FC_RD_HOLD, `MB_FC_RD_IN, `MB_FC_WR_ONE,
    `MB_FC_WR_MULTI, `MB_FC_IDENT}) |=> kind == RS_EXC && exc == `MB_EXC_FUNC
    && rlen == 8'h05 && state == ST_RESP) else $error("no exception answer");
  a_float_read_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_CHECK && fc == `MB_FC_RD_HOLD && cnt == 16'h0002
    && area_of(start, cnt) == AR_FLT |=> rlen == 8'h0d) else $error("float byte count");
  a_single_echo: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_CHECK && fc == `MB_FC_WR_ONE && area_of(start, 16'h0001) == AR_INT
    |=> s_write_then_resp ##0 kind == RS_ECHO && rlen == 8'h08) else $error("echo flow");
  a_single_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_WRITE && fc == `MB_FC_WR_ONE
    |=> ints[IW'(start - `MB_BASE_INT)] == cnt) else $error("value not stored");
  a_ident_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_CHECK && fc == `MB_FC_IDENT |=> kind == RS_IDENT && rlen == 8'h07)
    else $error("ident answer");
  a_m7_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RESP && kind == RS_READ && area == AR_M7 && !start[0] && tidx == 8'h03
    && push |-> push_data == flt[FW'((start - `MB_BASE_M7) >> 1)][31:24])
    else $error("mirror order");
  a_m6_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RESP && kind == RS_READ && area == AR_M6 && !start[0] && tidx == 8'h03
    && push |-> push_data == flt[FW'((start - `MB_BASE_M6) >> 1)][15:8])
    else $error("swapped mirror order");
  a_wdog_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_RESP && tidx == 8'h00 |-> wdog < 32'(RESP_CYC)) else $error("answer late");
endmodule : mbs_slave

// File: verif/mbs_master_model.sv
// Purpose: bus master model that feeds request bytes and collects answer bytes
// Assumes: one byte per rx_valid pulse, checksum appended low byte first
// Notes: rx_data shows the inverted last byte between bytes
`timescale 1ns/1ps
module mbs_master_model (
  input wire logic ref_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_char_err,
  output logic rx_frame_end,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_char_err = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end

  // ----------------------------------------
  // checksum and transfers
  // ----------------------------------------
  // crc-16 over a byte list, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // send fields in the given order, checksum last, then mark end of frame
  task automatic send(input logic [7:0] q[$], input logic good_crc, input logic bad_char);
    logic [15:0] c;
    logic [7:0] f[$];
    f = q;
    c = crc16(q) ^ {15'h0000, !good_crc};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge ref_clk);
      rx_data <= f[i];
      rx_valid <= 1'b1;
      rx_char_err <= (bad_char && i == 1);
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_char_err <= 1'b0;
      rx_data <= ~f[i];
    end
    @(posedge ref_clk);
    rx_frame_end <= 1'b1;
    @(posedge ref_clk);
    rx_frame_end <= 1'b0;
  endtask : send

  // collect n answer bytes, holding ready low for the first stall cycles
  task automatic take(output logic [7:0] a[$], input int n, input int stall);
    int k;
    a.delete();
    k = 0;
    tx_ready <= (stall == 0);
    while (a.size() < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
      if (k == stall) begin
        tx_ready <= 1'b1;
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        a.push_back(tx_data);
      end
    end
  endtask : take
endmodule : mbs_master_model

// File: verif/tb_modbus_rtu_register_access_slave.sv
// Purpose: self-checking bench of the serial register-access slave
// Assumes: own address 01, answer watchdog shortened to 200 cycles
// Notes: expected answers carry a checksum computed here
`timescale 1ns/1ps
module tb_modbus_rtu_register_access_slave;
  typedef logic [7:0] bq_t[$];
  logic ref_clk;
  logic rst_n;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_char_err;
  logic rx_frame_end;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic frame_drop;
  logic meas_we;
  logic [2:0] meas_idx;
  logic [31:0] meas_val;
  int failures;
  int checks_done;
  int drops;

  // ----------------------------------------
  // clock, reset, instances
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    meas_we = 1'b0;
    meas_idx = 3'h0;
    meas_val = 32'h0;
    failures = 0;
    checks_done = 0;
    drops = 0;
  end
  always #2 ref_clk = ~ref_clk;

  mbs_slave #(.RESP_CYC(200)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .slave_addr(8'h01),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_char_err(rx_char_err),
    .rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .frame_drop(frame_drop), .meas_we(meas_we),
    .meas_idx(meas_idx), .meas_val(meas_val)
  );

  mbs_master_model m (
    .ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_char_err(rx_char_err), .rx_frame_end(rx_frame_end),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  // count discard pulses
  always @(posedge ref_clk) begin
    if (frame_drop === 1'b1) begin
      drops <= drops + 1;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // low n bytes of a packed literal, first byte leftmost
  function automatic bq_t bq(input logic [127:0] v, input int n);
    bq_t q;
    for (int i = 0; i < n; i++) begin
      q.push_back(v[8*(n-1-i) +: 8]);
    end
    return q;
  endfunction : bq

  task automatic load(input logic [2:0] i, input logic [31:0] v);
    @(posedge ref_clk);
    meas_we <= 1'b1;
    meas_idx <= i;
    meas_val <= v;
    @(posedge ref_clk);
    meas_we <= 1'b0;
  endtask : load

  // one request, whole answer compared byte by byte, then silence
  task automatic xfer(input string nm, input bq_t req, input bq_t exp, input int stall);
    bq_t got;
    logic [15:0] c;
    c = m.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    m.send(req, 1'b1, 1'b0);
    m.take(got, exp.size(), stall);
    chk(nm, 16'(exp.size()), 16'(got.size()));
    foreach (exp[i]) chk(nm, {8'h00, exp[i]}, {8'h00, (i < got.size()) ? got[i] : 8'hxx});
    repeat (6) @(posedge ref_clk);
    chk(nm, 16'h0000, {15'h0000, tx_valid});
  endtask : xfer

  // frame that must be discarded: one drop pulse, no answer
  task automatic drop_one(input string nm, input bq_t req, input logic good, input logic bad);
    int d0;
    d0 = drops;
    m.send(req, good, bad);
    repeat (12) @(posedge ref_clk);
    chk(nm, 16'(d0 + 1), 16'(drops));
    chk(nm, 16'h0000, {15'h0000, tx_valid});
  endtask : drop_one

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reads;
    load(3'h0, 32'h41200000);
    load(3'h1, 32'h42c80000);
    xfer("rd_hold", bq(48'h01031d4c0002, 6), bq(88'h01030841200000_42c80000, 11), 0);
    xfer("rd_input", bq(48'h01041d4c0002, 6), bq(88'h01040841200000_42c80000, 11), 0);
  endtask : t_reads

  task automatic t_mirrors;
    load(3'h1, 32'h41cd70a4);
    load(3'h2, 32'h41a20000);
    xfer("mirror7", bq(48'h01031b5a0004, 6), bq(88'h01030841cd70a4_41a20000, 11), 0);
    xfer("mirror6", bq(48'h010317720004, 6), bq(88'h01030870a441cd_000041a2, 11), 0);
  endtask : t_mirrors

  task automatic t_writes;
    xfer("wr_one", bq(48'h01060fa1021f, 6), bq(48'h01060fa1021f, 6), 0);
    xfer("wr_one_rd", bq(48'h01030fa10001, 6), bq(40'h010302021f, 5), 0);
    xfer("wr_multi", bq(120'h01101d4c00020841a0000043480000, 15),
         bq(48'h01101d4c0002, 6), 0);
    xfer("wr_multi_rd", bq(48'h01031d4c0002, 6), bq(88'h01030841a00000_43480000, 11), 0);
  endtask : t_writes

  task automatic t_ident_exc;
    xfer("ident", bq(16'h0111, 2), bq(40'h0111025aff, 5), 0);
    xfer("exc_func", bq(48'h01070fa00001, 6), bq(24'h018701, 3), 0);
    xfer("exc_count", bq(48'h01030fa00000, 6), bq(24'h018303, 3), 0);
    xfer("exc_area", bq(48'h01061d4c0001, 6), bq(24'h018602, 3), 0);
  endtask : t_ident_exc

  task automatic t_drops;
    drop_one("bad_crc", bq(48'h01060fa20055, 6), 1'b0, 1'b0);
    drop_one("other_addr", bq(48'h02060fa20055, 6), 1'b1, 1'b0);
    drop_one("char_err", bq(48'h01060fa20055, 6), 1'b1, 1'b1);
    xfer("drop_rd", bq(48'h01030fa20001, 6), bq(40'h0103020000, 5), 0);
  endtask : t_drops

  // 37-byte answer overfills the fifo while the sink stalls
  task automatic t_fifo;
    bq_t e;
    e = bq(24'h010320, 3);
    for (int i = 0; i < 16; i++) begin
      e.push_back((i == 1) ? 8'h02 : 8'h00);
      e.push_back((i == 1) ? 8'h1f : 8'h00);
    end
    xfer("fifo_full", bq(48'h01030fa00010, 6), e, 100);
  endtask : t_fifo

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic close_out;
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reads;
    t_mirrors;
    t_writes;
    t_ident_exc;
    t_drops;
    t_fifo;
    close_out;
  end

  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out;
  end
endmodule : tb_modbus_rtu_register_access_slave
